// ---- logic/fct_core.sv ----
// Fast-charge termination controller with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "fct_params.svh"

module fct_core
  import fct_pkg::*;
#(
  parameter int unsigned ADC_W      = 12,                                    // ADC sample width
  parameter int unsigned SEC_CYC    = `FCT_CLK_MHZ * 1000000,               // Cycles in one second
  parameter int unsigned DROP_LSB   = int'($ceil(`FCT_DROP_MV * 1000.0 / `FCT_LSB_UV)) // Drop in LSB
) (
  input  wire logic             pclk,          // System clock
  input  wire logic             presetn,       // Async reset, active low
  input  wire logic             psel,          // APB select
  input  wire logic             penable,       // APB enable
  input  wire logic             pwrite,        // APB direction
  input  wire logic [11:0]      paddr,         // APB byte address
  input  wire logic [31:0]      pwdata,        // APB write data
  output logic      [31:0]      prdata,        // APB read data
  output logic                  pready,        // APB ready
  output logic                  pslverr,       // APB error
  input  wire fct_cmp_t         cmp,           // Comparator levels
  input  wire logic [ADC_W-1:0] adc_data,      // Sampled battery_sense_input
  input  wire logic             adc_valid,     // ADC result strobe
  output logic                  adc_start,     // ADC conversion request
  output logic                  switch_modulation_output, // Power switch drive
  output logic                  timer_program_low,        // Pull timer_program_input low
  output logic                  status_led_n,  // Status indicator, active low
  output logic                  cap_measure    // Measure timer_capacitor
);

  localparam int unsigned QUIET_CYC = `FCT_NS_TO_CYC(`FCT_QUIET_NS);   // Quiet time before sample
  localparam int unsigned MEAS_CYC  = `FCT_NS_TO_CYC(`FCT_MEASURE_NS); // Capacitor measure time
  localparam int unsigned PER_CYC   = int'(`FCT_TRICKLE_PER_S * SEC_CYC); // Trickle period
  localparam logic [8:0]  MTO_SLOTS = 9'(`FCT_SLOTS_PER_MTO);           // Slots in one timer span
  localparam logic [8:0]  HOLD_SLOTS = 9'(`FCT_SLOTS_PER_MTO / `FCT_HOLDOFF_DIV); // Hold-off slots

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  ////////////////////////////////////////////////////////////////////////
  logic             enable;      // Charging enabled by software
  logic [31:0]      slot_len;    // Cycles per timer slot
  logic [31:0]      pulse_len;   // Trickle pulse width in cycles
  fct_state_t       state;       // Charge state
  fct_state_t       resume_st;   // Fast phase to resume after cold
  logic             lithium;     // Pack classified as lithium
  logic             peak_seen;   // Peak drop detected
  logic [31:0]      slot_cnt;    // Time-base counter
  logic             slot_tick;   // One pulse per slot
  logic [8:0]       remain;      // Remaining timer slots
  logic [8:0]       elapsed;     // Slots since fast charge began
  logic [ADC_W-1:0] peak_max;    // Highest sample so far
  logic [31:0]      sec_cnt;     // One-second counter
  logic [31:0]      quiet_cnt;   // Quiet window counter
  logic             sampling;    // Sample sequence active
  logic             adc_wait;    // Waiting for ADC result
  logic [31:0]      meas_cnt;    // Measurement cycle count
  logic             meas_done;   // Measurement window over

  // Timer runs in fast charge and top-off
  function automatic logic timer_run(input fct_state_t s);
    return (s == FCT_FAST_CC) || (s == FCT_FAST_CV) || (s == FCT_TOPOFF);
  endfunction

  // True in either fast-charge phase
  function automatic logic in_fast(input fct_state_t s);
    return (s == FCT_FAST_CC) || (s == FCT_FAST_CV);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  ////////////////////////////////////////////////////////////////////////
  logic setup_ph;     // Setup cycle of a transfer
  logic access_wr;    // Write completing this cycle
  logic mapped;       // Address hits a register
  assign setup_ph  = psel && !penable;
  assign access_wr = psel && penable && pwrite && pready;
  assign mapped    = (paddr == `FCT_CTRL_OFS) || (paddr == `FCT_SLOT_OFS) ||
                     (paddr == `FCT_PULSE_OFS) || (paddr == `FCT_STATUS_OFS) ||
                     (paddr == `FCT_PEAK_OFS) || (paddr == `FCT_TIMER_OFS);

  // Ready always high once out of reset; zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= !mapped;
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `FCT_CTRL_OFS:   prdata <= {31'h0000_0000, enable};
          `FCT_SLOT_OFS:   prdata <= slot_len;
          `FCT_PULSE_OFS:  prdata <= pulse_len;
          `FCT_STATUS_OFS: prdata <= {20'h00000, (elapsed < HOLD_SLOTS), peak_seen, lithium, state};
          `FCT_PEAK_OFS:   prdata <= 32'(peak_max);
          `FCT_TIMER_OFS:  prdata <= {23'h000000, remain};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable registers; slot length sets max_charge_time = 128 slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable    <= 1'b0;
      slot_len  <= `FCT_SLOT_RST;
      pulse_len <= `FCT_PULSE_RST;
    end else if (access_wr && !pslverr) begin
      unique case (paddr)
        `FCT_CTRL_OFS:  enable    <= pwdata[`FCT_CTRL_EN_BIT];
        `FCT_SLOT_OFS:  slot_len  <= pwdata;
        `FCT_PULSE_OFS: pulse_len <= pwdata;
        default:        enable    <= enable;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base
  ////////////////////////////////////////////////////////////////////////
  // Single slot counter paces timer, hold-off and sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt  <= 32'h0000_0000;
      slot_tick <= 1'b0;
    end else if (state == FCT_IDLE) begin
      slot_cnt  <= 32'h0000_0000;                           // Each charge starts on a slot edge
      slot_tick <= 1'b0;
    end else if (!timer_run(state)) begin
      slot_tick <= 1'b0;                                    // Paused, count held
    end else if (slot_cnt + 32'h0000_0001 >= slot_len) begin
      slot_cnt  <= 32'h0000_0000;
      slot_tick <= 1'b1;
    end else begin
      slot_cnt  <= slot_cnt + 32'h0000_0001;
      slot_tick <= 1'b0;
    end
  end

  // One-second period for pulses and flashing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt <= 32'h0000_0000;
    end else if (sec_cnt >= 32'(PER_CYC - 1)) begin
      sec_cnt <= 32'h0000_0000;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge timer
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain  <= 9'h000;
      elapsed <= 9'h000;
    end else if (state == FCT_IDLE) begin
      remain  <= MTO_SLOTS;
      elapsed <= 9'h000;
    end else if (state == FCT_FAST_CC && cmp.at_max_cell && !cmp.below_cutoff && !cmp.above_cold) begin
      remain  <= remain + MTO_SLOTS;                        // Extra span for CV
    end else if (state == FCT_MEASURE) begin
      remain  <= MTO_SLOTS;                                 // Fresh span for top-off
    end else if (slot_tick && remain != 9'h000) begin
      remain  <= remain - 9'h001;
      if (elapsed != MTO_SLOTS) begin
        elapsed <= elapsed + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peak-drop sampling
  ////////////////////////////////////////////////////////////////////////
  // Quiet, convert, compare once per slot in CC only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampling  <= 1'b0;
      adc_wait  <= 1'b0;
      adc_start <= 1'b0;
      quiet_cnt <= 32'h0000_0000;
      peak_max  <= '0;
      peak_seen <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (state == FCT_IDLE) begin
        peak_max  <= '0;
        peak_seen <= 1'b0;
        sampling  <= 1'b0;
        adc_wait  <= 1'b0;
      end else if (state != FCT_FAST_CC || lithium) begin
        sampling  <= 1'b0;                                  // Off after lithium found
        adc_wait  <= 1'b0;
      end else if (slot_tick && !sampling && remain != 9'h001) begin // No sample on the expiring tick
        sampling  <= 1'b1;                                  // Begin quiet phase
        quiet_cnt <= 32'h0000_0000;
      end else if (sampling && !adc_wait) begin
        if (quiet_cnt >= 32'(QUIET_CYC - 1)) begin
          adc_start <= 1'b1;
          adc_wait  <= 1'b1;
        end else begin
          quiet_cnt <= quiet_cnt + 32'h0000_0001;
        end
      end else if (adc_wait && adc_valid) begin
        sampling <= 1'b0;
        adc_wait <= 1'b0;
        if (adc_data > peak_max) begin
          peak_max <= adc_data;
        end else if (elapsed >= HOLD_SLOTS &&                 // Held off early on
                     (peak_max - adc_data) >= ADC_W'(DROP_LSB)) begin
          peak_seen <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge state machine
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= FCT_IDLE;
      resume_st <= FCT_FAST_CC;
      lithium   <= 1'b0;
    end else if (!enable) begin
      state   <= FCT_IDLE;
      lithium <= 1'b0;
    end else begin
      unique case (state)
        FCT_IDLE: begin
          state <= FCT_FAST_CC;
        end
        FCT_FAST_CC, FCT_FAST_CV: begin
          // Warm comparator not consulted here
          if (cmp.below_cutoff) begin
            state <= FCT_SUSPEND;                           // Over-temperature end
          end else if (cmp.above_cold) begin
            resume_st <= state;
            state     <= FCT_COND;                          // Pause and condition
          end else if (state == FCT_FAST_CC && cmp.at_max_cell) begin
            lithium <= 1'b1;                                // Lithium, go to CV
            state   <= FCT_FAST_CV;
          end else if (state == FCT_FAST_CC && (remain == 9'h000 || peak_seen)) begin
            state <= FCT_MEASURE;                           // Nickel end, expiry too
          end else if (state == FCT_FAST_CV && (cmp.current_taper || remain == 9'h000)) begin
            state <= FCT_DONE;                              // Taper ends lithium charge
          end
        end
        FCT_COND: begin
          if (cmp.below_cutoff) begin
            state <= FCT_SUSPEND;
          end else if (!cmp.above_cold) begin
            state <= resume_st;                             // Timer continues
          end
        end
        FCT_MEASURE: begin
          if (meas_done) begin
            state <= cmp.cap_large ? FCT_TOPOFF : FCT_TRICKLE; // Choose stage
          end
        end
        FCT_TOPOFF: begin
          if (cmp.at_max_cell) begin
            state <= FCT_DONE;
          end else if (remain == 9'h000 || cmp.below_cutoff) begin
            state <= cmp.below_cutoff ? FCT_SUSPEND : FCT_TRICKLE;
          end
        end
        FCT_TRICKLE: begin
          if (cmp.at_max_cell) begin
            state <= FCT_DONE;
          end
        end
        FCT_SUSPEND: begin
          if (cmp.above_warm) begin
            state <= lithium ? FCT_DONE : FCT_TRICKLE;      // Resume as trickle, or done if lithium
          end
        end
        FCT_DONE: begin
          state <= FCT_DONE;
        end
        default: begin
          state <= FCT_IDLE;
        end
      endcase
    end
  end

  // Capacitor measurement window after nickel fast charge
  assign meas_done = (meas_cnt >= 32'(MEAS_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_cnt    <= 32'h0000_0000;
      cap_measure <= 1'b0;
    end else if (state == FCT_MEASURE && !meas_done) begin
      meas_cnt    <= meas_cnt + 32'h0000_0001;
      cap_measure <= 1'b1;                                  // Measure timer_capacitor
    end else begin
      meas_cnt    <= (state == FCT_MEASURE) ? meas_cnt : 32'h0000_0000;
      cap_measure <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drives
  ////////////////////////////////////////////////////////////////////////
  // Switch modulation: regulation, pulsed trickle, quiet during sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_modulation_output <= 1'b0;
      timer_program_low        <= 1'b0;
    end else begin
      timer_program_low <= sampling;                        // Timer pin low to sample
      if (sampling) begin
        switch_modulation_output <= 1'b0;                   // Quiet before sample
      end else if (cmp.at_max_cell && state != FCT_FAST_CV) begin
        switch_modulation_output <= 1'b0;                   // Never above max_cell_level
      end else if (in_fast(state)) begin
        switch_modulation_output <= !cmp.at_max_cell;       // Hold at max_cell_level
      end else if (state == FCT_COND || state == FCT_TRICKLE || state == FCT_TOPOFF) begin
        switch_modulation_output <= (sec_cnt < pulse_len);  // One pulse per second
      end else begin
        switch_modulation_output <= 1'b0;
      end
    end
  end

  // Status indicator, active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_led_n <= 1'b1;
    end else if (in_fast(state)) begin
      status_led_n <= 1'b0;                                 // Lit in fast charge
    end else if (state == FCT_COND) begin
      status_led_n <= (sec_cnt >= 32'(PER_CYC / 2));       // 1 Hz flash
    end else begin
      status_led_n <= 1'b1;                                 // Off when suspended
    end
  end

endmodule

`default_nettype wire

// ---- logic/fct_params.svh ----
// Constants for the fast-charge termination block
`ifndef FCT_PARAMS_SVH
`define FCT_PARAMS_SVH
// Register byte offsets
`define FCT_CTRL_OFS     12'h000
`define FCT_SLOT_OFS     12'h004
`define FCT_PULSE_OFS    12'h008
`define FCT_STATUS_OFS   12'h00c
`define FCT_PEAK_OFS     12'h010
`define FCT_TIMER_OFS    12'h014
// Control fields
`define FCT_CTRL_EN_BIT  0
// Reset values
`define FCT_SLOT_RST     32'h0000_1000
`define FCT_PULSE_RST    32'h0000_0400
// Timer geometry: one max_charge_time is this many sample slots
`define FCT_SLOTS_PER_MTO 128
`define FCT_HOLDOFF_DIV   32
// Peak drop threshold in millivolts and ADC step in microvolts
`define FCT_DROP_MV       3.8
`define FCT_LSB_UV        1000.0
// Clock and timing
`define FCT_CLK_MHZ       125
`define FCT_TRICKLE_PER_S 1.0
`define FCT_QUIET_NS      400
`define FCT_MEASURE_NS    2000
`define FCT_NS_TO_CYC(ns) ((((ns) * `FCT_CLK_MHZ) + 999) / 1000)
`endif

// ---- logic/fct_pkg.sv ----
// Types shared by the fast-charge termination block
package fct_pkg;
  // Charge states, one-hot
  typedef enum logic [8:0] {
    FCT_IDLE    = 9'h001,
    FCT_COND    = 9'h002,
    FCT_FAST_CC = 9'h004,
    FCT_FAST_CV = 9'h008,
    FCT_MEASURE = 9'h010,
    FCT_TOPOFF  = 9'h020,
    FCT_TRICKLE = 9'h040,
    FCT_SUSPEND = 9'h080,
    FCT_DONE    = 9'h100
  } fct_state_t;

  // Comparator levels from the analog front end
  typedef struct packed {
    logic above_cold;    // thermistor_input above cold_limit_level
    logic above_warm;    // thermistor_input above warm_limit_level
    logic below_cutoff;  // thermistor_input below cutoff_temp_level
    logic at_max_cell;   // battery_sense_input at max_cell_level
    logic current_taper; // charge current at or below 14 % of maximum
    logic cap_large;     // timer_capacitor large enough for top-off
  } fct_cmp_t;
endpackage

// ---- testbench/fct_core_props.sv ----
// Port assertions for the fast-charge termination block
`timescale 1ns/1ps
`default_nettype none

module fct_core_props (
  input wire logic pclk,                     // Clock
  input wire logic presetn,                  // Reset, active low
  input wire logic psel,                     // APB select
  input wire logic penable,                  // APB enable
  input wire logic pready,                   // APB ready
  input wire logic adc_valid,                // ADC result strobe
  input wire logic adc_start,                // ADC request
  input wire logic switch_modulation_output, // Switch drive
  input wire logic timer_program_low,        // Timer pin pulled low
  input wire logic cap_measure               // Capacitor measurement
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  // Sampling keeps the switch off for the whole quiet window
  quiet_switch_a: assert property (timer_program_low |-> !switch_modulation_output)
    else $error("switch on during quiet window");
  quiet_first_a: assert property ($rose(timer_program_low) |-> !adc_start [*8])
    else $error("conversion without settling time");
  sample_due_a: assert property ($rose(timer_program_low) |-> ##[1:60] adc_start)
    else $error("quiet window without conversion");
  sample_done_a: assert property (timer_program_low && adc_valid |-> ##2 !timer_program_low)
    else $error("timer pin held after result");
  start_gap_a: assert property (adc_start |=> !adc_start [*8])
    else $error("conversions too close");
  start_quiet_a: assert property (adc_start |-> timer_program_low && !switch_modulation_output)
    else $error("conversion while circuits active");
  measure_idle_a: assert property (cap_measure |-> !adc_start && !timer_program_low)
    else $error("sampling during capacitor measurement");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("bus access stalled");
endmodule

bind fct_core fct_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .adc_valid(adc_valid), .adc_start(adc_start), .cap_measure(cap_measure),
  .switch_modulation_output(switch_modulation_output), .timer_program_low(timer_program_low));

`default_nettype wire

// ---- testbench/fct_pack_model.sv ----
// Battery pack front end answering each conversion request after a lag
`timescale 1ns/1ps
`default_nettype none

module fct_pack_model (
  input  wire logic        pclk,      // Clock
  input  wire logic        presetn,   // Reset, active low
  input  wire logic        adc_start, // Conversion request
  input  wire logic [11:0] level,     // Battery level to report
  input  wire logic [3:0]  lag,       // Cycles before the answer
  output logic      [11:0] adc_data,  // Sample, scrambled when idle
  output logic             adc_valid  // Result strobe
);
  logic       busy; // Conversion in flight
  logic [3:0] cnt;  // Remaining lag
  //////////////////////////////////////////////////////////////////////////////
  // Data inverts every idle cycle so nothing stale can pass as a sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      cnt       <= 4'h0;
      adc_valid <= 1'b0;
      adc_data  <= 12'h000;
    end else begin
      adc_valid <= 1'b0;
      adc_data  <= ~adc_data;
      if (adc_start) begin
        busy <= 1'b1;
        cnt  <= lag;
      end else if (busy && cnt == 4'h0) begin
        busy      <= 1'b0;
        adc_valid <= 1'b1;
        adc_data  <= level;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- testbench/test_fast_charge_termination.sv ----
// Self-checking bench for the fast-charge termination block
`timescale 1ns/1ps
`default_nettype none
`include "fct_params.svh"

module test_fast_charge_termination
  import fct_pkg::*;
;
  localparam logic [11:0] SL = `FCT_SLOT_OFS;
  localparam logic [11:0] ST = `FCT_STATUS_OFS;
  localparam logic [11:0] TM = `FCT_TIMER_OFS;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk; logic err;} fct_note_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, noted = 1'b0;
  logic [11:0] paddr = 12'h000, level = 12'h064;
  logic [31:0] pwdata = 32'h0, rd_val, t_a, t_b;
  logic [3:0]  lag = 4'h0;
  logic [7:0]  lfsr = 8'h5e;
  fct_cmp_t    cmp = 6'h11;
  logic [31:0] prdata;
  logic [11:0] adc_data;
  logic        pready, pslverr, adc_valid, adc_start, sw, tpl, led_n, cap_m, saw_cap = 1'b0;
  fct_note_t   notes[$];
  fct_note_t   nt;
  int          err_count = 0, n_checks = 0, cyc = 0, t0 = 0, nl, ns;

  fct_core #(.SEC_CYC(500)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp(cmp), .adc_data(adc_data), .adc_valid(adc_valid), .adc_start(adc_start),
    .switch_modulation_output(sw), .timer_program_low(tpl), .status_led_n(led_n), .cap_measure(cap_m));
  fct_pack_model u_pack (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .level(level),
    .lag(lag), .adc_data(adc_data), .adc_valid(adc_valid));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  always #4 pclk = ~pclk;
  // Cycle count, capacitor watch and hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cap_m === 1'b1)
      saw_cap <= 1'b1;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  // Read monitor takes the oldest note at each read access made by rd
  always @(posedge pclk) begin
    if (noted === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      nt = notes.pop_front();
      chk(nt.nm, prdata & nt.msk, nt.exp);
      chk(nt.nm, {31'h0, pslverr}, {31'h0, nt.err});
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready, then an idle cycle
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    lfsr = lfsr_next(lfsr);
    lag <= lfsr[3:0];
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    noted <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff, input logic er = 1'b0);
    notes.push_back('{nm, e, m, er});
    noted <= 1'b1;
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic begin_charge();
    xfer(`FCT_CTRL_OFS, 1'b1, 32'h0);
    xfer(`FCT_CTRL_OFS, 1'b1, 32'h1);
    t0 = cyc;
  endtask
  task automatic at(input int n);
    while (cyc < t0 + n) @(posedge pclk);
  endtask
  // Wait until just after a sample so a state change cannot cut one short
  task automatic calm();
    @(negedge tpl);
    repeat (4) @(posedge pclk);
  endtask
  task automatic wait_st(input logic [8:0] s);
    int i;
    xfer(ST, 1'b0, 32'h0);
    for (i = 0; i < 1000 && rd_val[8:0] !== s; i++) begin
      repeat (20) @(posedge pclk);
      xfer(ST, 1'b0, 32'h0);
    end
  endtask
  // Count rising edges of indicator and switch
  task automatic edges(input int n);
    logic pl, ps;
    pl = led_n;
    ps = sw;
    nl = 0;
    ns = 0;
    repeat (n) begin
      @(posedge pclk);
      nl += int'(led_n === 1'b1 && pl === 1'b0);
      ns += int'(sw === 1'b1 && ps === 1'b0);
      pl = led_n;
      ps = sw;
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, unmapped place, slot of 128 cycles
    chk("led_idle", {31'h0, led_n}, 32'h1);
    rd("slot_rst", SL, `FCT_SLOT_RST);
    rd("pulse_rst", `FCT_PULSE_OFS, `FCT_PULSE_RST);
    rd("idle", ST, 32'h001, 32'h1ff);
    rd("unmapped", 12'h040, 32'h0, 32'hffff_ffff, 1'b1);
    xfer(SL, 1'b1, 32'h80);
    xfer(`FCT_PULSE_OFS, 1'b1, 32'h20);
    rd("slot", SL, 32'h80);
    // Drop in hold-off ignored, later drop ends charge
    begin_charge();
    at(200);
    rd("holdoff", ST, 32'h804, 32'hfff);
    chk("led_fast", {31'h0, led_n}, 32'h0);
    at(400);
    level <= 12'h028;
    at(490);
    level <= 12'h064;
    at(580);
    rd("holdoff_end", ST, 32'h004, 32'hfff);
    at(600);
    level <= 12'h0c8;
    at(900);
    level <= 12'h0c5;
    at(1020);
    rd("small_drop", ST, 32'h004, 32'h5ff);
    level <= 12'h0c4;
    wait_st(FCT_TOPOFF);
    rd("peak_topoff", ST, 32'h420, 32'h7ff);
    rd("timer_reset", TM, 32'h80);
    chk("cap_seen", {31'h0, saw_cap}, 32'h1);
    // Cold pause, blink, resume
    begin_charge();
    calm();
    cmp.above_cold <= 1'b1;
    repeat (3) @(posedge pclk);
    rd("cold", ST, 32'h002, 32'h1ff);
    xfer(TM, 1'b0, 32'h0);
    t_a = rd_val;
    edges(2000);
    chk("blink", {31'h0, nl >= 3 && nl <= 5}, 32'h1);
    chk("pulses", {31'h0, ns >= 3 && ns <= 5}, 32'h1);
    rd("paused", TM, t_a);
    cmp.above_cold <= 1'b0;
    repeat (3) @(posedge pclk);
    rd("resume", ST, 32'h004, 32'h1ff);
    rd("timer_kept", TM, t_a);
    cmp.above_warm <= 1'b0;
    repeat (300) @(posedge pclk);
    rd("warm_off", ST, 32'h004, 32'h1ff);
    // Cutoff suspends, warm exit goes to maintenance
    calm();
    cmp.below_cutoff <= 1'b1;
    repeat (3) @(posedge pclk);
    rd("cutoff", ST, 32'h080, 32'h1ff);
    chk("led_off", {31'h0, led_n}, 32'h1);
    cmp.below_cutoff <= 1'b0;
    repeat (20) @(posedge pclk);
    rd("still_hot", ST, 32'h080, 32'h1ff);
    cmp.above_warm <= 1'b1;
    repeat (3) @(posedge pclk);
    rd("to_trickle", ST, 32'h040, 32'h1ff);
    // Lithium: timer extended, no samples, taper ends charge
    begin_charge();
    at(600);
    calm();
    xfer(TM, 1'b0, 32'h0);
    t_a = rd_val;
    cmp.at_max_cell <= 1'b1;
    repeat (3) @(posedge pclk);
    xfer(TM, 1'b0, 32'h0);
    t_b = rd_val - t_a;
    chk("extend", {31'h0, t_b == 32'h80 || t_b == 32'h7f}, 32'h1);
    rd("lithium", ST, 32'h208, 32'h3ff);
    chk("sw_cap", {31'h0, sw}, 32'h0);
    edges(0);
    repeat (400) begin
      @(posedge pclk);
      ns += int'(adc_start === 1'b1);
    end
    chk("no_sample", 32'(ns), 32'h0);
    cmp.current_taper <= 1'b1;
    repeat (3) @(posedge pclk);
    rd("taper", ST, 32'h100, 32'h1ff);
    cmp <= 6'h10;
    // Timer expiry in constant current, no top-off
    begin_charge();
    wait_st(FCT_TRICKLE);
    chk("expiry", {31'h0, cyc - t0 > 16300 && cyc - t0 < 16800}, 32'h1);
    rd("nickel_trickle", ST, 32'h040, 32'h7ff);
    end_of_test();
  end
endmodule

`default_nettype wire
